// ---- rtl/tcc_config_regs.sv ----
/*
 * tcc_config_regs: configuration and status register bank for the
 * converter loop, the system clock divider and the bias calibration.
 * assumes: a serial port front end drives the simple register port on
 * mclk; analog-side status inputs are synchronous to mclk.
 */
//
// Behaviour
// - reference code 0..4: bypass, 2, 4, 8, 16
// - modulator off means integer-only feedback division
// - order codes: integer, first, second; 3 reserved
// - feedback integer is 8 bits, resets 0x23
// - feedback fraction 16 bits, resets 0x2800
// - dac code is baseline plus dynamic 0..16
// - done bit reads 0 running, 1 complete
// - fail bit: 0 success, 1 failure, when done
// - selected bias setting, valid once done
// - applied bias setting, valid once done
// - status bit 8 shows raw comparator output
`timescale 1ns/1ps
`default_nettype none

module tcc_config_regs (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port from the serial front end
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    output logic [15:0] reg_rdata,
    output logic reg_rvalid,
    // dac modulator dynamic term
    input wire logic [4:0] dac_dynamic,
    // bias calibration results
    input wire logic bias_cal_done_in,
    input wire logic bias_cal_fail_in,
    input wire logic [2:0] bias_cal_sel_in,
    input wire logic [2:0] bias_cal_eff_in,
    input wire logic bias_cal_cmp_in,
    // converter loop settings
    output logic [4:0] ref_divide_ratio,
    output logic multi_modulus_divider_active,
    output logic [1:0] feedback_modulator_order,
    output logic [7:0] feedback_integer_value,
    output logic [15:0] feedback_fraction_value,
    output logic [5:0] dac_code,
    // system clock divider setting
    output logic [4:0] sys_divide_integer
);

    // stored fields, one per register field
    logic [2:0] ref_code_r; // reference divider code
    logic fb_en_r; // feedback modulator enable
    logic [1:0] fb_order_r; // feedback modulator order
    logic [7:0] fb_int_r; // feedback integer
    logic [15:0] fb_frac_r; // feedback fraction
    logic [4:0] dac_base_r; // dac baseline
    logic [4:0] sys_div_r; // system divide integer

    // output registers for the settings
    logic [4:0] ref_ratio_r;
    logic mmd_active_r;
    logic [1:0] order_out_r;
    logic [7:0] int_out_r;
    logic [15:0] frac_out_r;
    logic [5:0] dac_code_r;
    logic [4:0] sys_div_out_r;

    // read path registers
    logic [15:0] rdata_r;
    logic [15:0] rdata_nxt;
    logic rvalid_r;

    // decoded settings, combinational
    logic [4:0] ref_ratio_nxt;
    logic mmd_active_nxt;
    logic [1:0] order_nxt;
    logic [15:0] frac_nxt;
    logic [5:0] dac_code_nxt;

    // bias status word as software sees it
    logic [15:0] bias_status;

    // write decode strobes
    logic wr_ref;
    logic wr_fb_mod;
    logic wr_fb_int;
    logic wr_fb_frac;
    logic wr_dac;
    logic wr_sys;

    // address decode for writes; status index takes no write
    always_comb begin
        wr_ref = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_REF_DIV);
        wr_fb_mod = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_FB_MOD);
        wr_fb_int = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_FB_INT);
        wr_fb_frac = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_FB_FRAC);
        wr_dac = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_DAC_BASE);
        wr_sys = reg_wr_en && (reg_addr == tcc_regs_pkg::ADDR_SYS_DIV);
    end

    // reference divider field; upper bits are never stored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_code_r <= tcc_regs_pkg::REF_DIV_RST;
        end else if (wr_ref) begin
            ref_code_r <= reg_wdata[tcc_regs_pkg::REF_DIV_LSB +: tcc_regs_pkg::REF_DIV_W];
        end
    end

    // modulator enable and order
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fb_en_r <= tcc_regs_pkg::FB_EN_RST;
            fb_order_r <= tcc_regs_pkg::FB_ORDER_RST;
        end else if (wr_fb_mod) begin
            fb_en_r <= reg_wdata[tcc_regs_pkg::FB_EN_BIT];
            // reserved order code is refused, the old order stays
            if (reg_wdata[tcc_regs_pkg::FB_ORDER_LSB +: tcc_regs_pkg::FB_ORDER_W]
                    != tcc_regs_pkg::ORDER_RESERVED) begin
                fb_order_r <= reg_wdata[tcc_regs_pkg::FB_ORDER_LSB +:
                                        tcc_regs_pkg::FB_ORDER_W];
            end
        end
    end

    // feedback integer value
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fb_int_r <= tcc_regs_pkg::FB_INT_RST;
        end else if (wr_fb_int) begin
            fb_int_r <= reg_wdata[7:0];
        end
    end

    // feedback fraction value, weight two to the minus sixteen per lsb
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            fb_frac_r <= tcc_regs_pkg::FB_FRAC_RST;
        end else if (wr_fb_frac) begin
            fb_frac_r <= reg_wdata;
        end
    end

    // dac baseline; codes above 0x10 are stored as written
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dac_base_r <= tcc_regs_pkg::DAC_BASE_RST;
        end else if (wr_dac) begin
            dac_base_r <= reg_wdata[tcc_regs_pkg::DAC_BASE_LSB +:
                                    tcc_regs_pkg::DAC_BASE_W];
        end
    end

    // system clock divide integer; range is left to software
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_div_r <= tcc_regs_pkg::SYS_DIV_RST;
        end else if (wr_sys) begin
            sys_div_r <= reg_wdata[tcc_regs_pkg::SYS_DIV_LSB +:
                                   tcc_regs_pkg::SYS_DIV_W];
        end
    end

    // field decode into analog settings
    tcc_setting_decode i_tcc_setting_decode (
        .ref_code(ref_code_r),
        .feedback_modulator_enable(fb_en_r),
        .feedback_modulator_order(fb_order_r),
        .feedback_fraction_value(fb_frac_r),
        .dac_baseline(dac_base_r),
        .dac_dynamic(dac_dynamic),
        .ref_divide_ratio(ref_ratio_nxt),
        .multi_modulus_divider_active(mmd_active_nxt),
        .modulator_order_eff(order_nxt),
        .fraction_eff(frac_nxt),
        .dac_code(dac_code_nxt)
    );

    // reference divide ratio setting, registered so the output leaves a flip-flop
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            ref_ratio_r <= 5'h02;
        end else begin
            ref_ratio_r <= ref_ratio_nxt;
        end
    end

    // modulator enable, order and fraction move together, so the loop
    // never sees an order or fraction from a different enable state
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            mmd_active_r <= tcc_regs_pkg::FB_EN_RST;
            order_out_r <= tcc_regs_pkg::FB_ORDER_RST;
            frac_out_r <= tcc_regs_pkg::FB_FRAC_RST;
        end else begin
            mmd_active_r <= mmd_active_nxt;
            order_out_r <= order_nxt;
            frac_out_r <= frac_nxt;
        end
    end

    // feedback integer setting
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            int_out_r <= tcc_regs_pkg::FB_INT_RST;
        end else begin
            int_out_r <= fb_int_r;
        end
    end

    // dac input code; follows the dynamic term one cycle late
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            dac_code_r <= 6'h04;
        end else begin
            dac_code_r <= dac_code_nxt;
        end
    end

    // system divide setting, passed on as stored
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            sys_div_out_r <= tcc_regs_pkg::SYS_DIV_RST;
        end else begin
            sys_div_out_r <= sys_div_r;
        end
    end

    // status word; calibration results are masked until done
    always_comb begin
        bias_status = 16'h0000;
        bias_status[tcc_regs_pkg::BIAS_DONE_BIT] = bias_cal_done_in;
        bias_status[tcc_regs_pkg::BIAS_FAIL_BIT] =
            bias_cal_done_in & bias_cal_fail_in;
        bias_status[tcc_regs_pkg::BIAS_SEL_LSB +: tcc_regs_pkg::BIAS_SET_W] =
            bias_cal_done_in ? bias_cal_sel_in : 3'h0;
        bias_status[tcc_regs_pkg::BIAS_EFF_LSB +: tcc_regs_pkg::BIAS_SET_W] =
            bias_cal_done_in ? bias_cal_eff_in : 3'h0;
        bias_status[tcc_regs_pkg::BIAS_RAW_BIT] = bias_cal_cmp_in;
    end

    // read mux; unmapped indices and reserved bits read zero
    always_comb begin
        rdata_nxt = 16'h0000;
        case (reg_addr)
            tcc_regs_pkg::ADDR_REF_DIV: begin
                rdata_nxt[tcc_regs_pkg::REF_DIV_LSB +: tcc_regs_pkg::REF_DIV_W] =
                    ref_code_r;
            end
            tcc_regs_pkg::ADDR_FB_MOD: begin
                rdata_nxt[tcc_regs_pkg::FB_EN_BIT] = fb_en_r;
                rdata_nxt[tcc_regs_pkg::FB_ORDER_LSB +: tcc_regs_pkg::FB_ORDER_W] =
                    fb_order_r;
            end
            tcc_regs_pkg::ADDR_FB_INT: begin
                rdata_nxt[7:0] = fb_int_r;
            end
            tcc_regs_pkg::ADDR_FB_FRAC: begin
                rdata_nxt = fb_frac_r;
            end
            tcc_regs_pkg::ADDR_DAC_BASE: begin
                rdata_nxt[tcc_regs_pkg::DAC_BASE_LSB +: tcc_regs_pkg::DAC_BASE_W] =
                    dac_base_r;
            end
            tcc_regs_pkg::ADDR_SYS_DIV: begin
                rdata_nxt[tcc_regs_pkg::SYS_DIV_LSB +: tcc_regs_pkg::SYS_DIV_W] =
                    sys_div_r;
            end
            tcc_regs_pkg::ADDR_BIAS_STS: begin
                rdata_nxt = bias_status;
            end
            default: begin
                rdata_nxt = 16'h0000;
            end
        endcase
    end

    // read data captured on the read strobe, held until the next read
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rdata_r <= 16'h0000;
        end else if (reg_rd_en) begin
            rdata_r <= rdata_nxt;
        end
    end

    // one-cycle pulse marking valid read data
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            rvalid_r <= 1'b0;
        end else begin
            rvalid_r <= reg_rd_en;
        end
    end

    // port outputs from the registers above
    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign ref_divide_ratio = ref_ratio_r;
    assign multi_modulus_divider_active = mmd_active_r;
    assign feedback_modulator_order = order_out_r;
    assign feedback_integer_value = int_out_r;
    assign feedback_fraction_value = frac_out_r;
    assign dac_code = dac_code_r;
    assign sys_divide_integer = sys_div_out_r;

endmodule

`default_nettype wire

// ---- rtl/tcc_regs_pkg.sv ----
/*
 * tcc_regs_pkg: register indices, field positions, reset values and
 * decode constants for the timing core configuration register bank.
 * assumes: one register per index on a flat 8-bit index space, data
 * up to 16 bits wide, with narrower registers held in the low bits.
 */
package tcc_regs_pkg;

    // register port widths
    localparam int ADDR_W = 8;
    localparam int DATA_W = 16;

    // register indices on the internal register port
    localparam logic [7:0] ADDR_REF_DIV = 8'h00; // converter_ref_divider_ctrl
    localparam logic [7:0] ADDR_FB_MOD = 8'h01; // converter_feedback_modulator_ctrl
    localparam logic [7:0] ADDR_FB_INT = 8'h02; // converter_feedback_integer
    localparam logic [7:0] ADDR_FB_FRAC = 8'h03; // converter_feedback_fraction
    localparam logic [7:0] ADDR_DAC_BASE = 8'h04; // converter_dac_baseline
    localparam logic [7:0] ADDR_SYS_DIV = 8'h05; // system_clock_divide_integer
    localparam logic [7:0] ADDR_BIAS_STS = 8'h06; // bias_calibration_status

    // reference divider field
    localparam int REF_DIV_LSB = 0;
    localparam int REF_DIV_W = 3;
    localparam logic [2:0] REF_DIV_RST = 3'h1;

    // reference divider codes
    localparam logic [2:0] REF_CODE_BYPASS = 3'h0;
    localparam logic [2:0] REF_CODE_DIV2 = 3'h1;
    localparam logic [2:0] REF_CODE_DIV4 = 3'h2;
    localparam logic [2:0] REF_CODE_DIV8 = 3'h3;
    localparam logic [2:0] REF_CODE_DIV16 = 3'h4;

    // feedback modulator fields
    localparam int FB_EN_BIT = 7;
    localparam int FB_ORDER_LSB = 0;
    localparam int FB_ORDER_W = 2;
    localparam logic FB_EN_RST = 1'b1;
    localparam logic [1:0] FB_ORDER_RST = 2'h1;

    // modulator order codes
    localparam logic [1:0] ORDER_INTEGER = 2'h0;
    localparam logic [1:0] ORDER_FIRST = 2'h1;
    localparam logic [1:0] ORDER_SECOND = 2'h2;
    localparam logic [1:0] ORDER_RESERVED = 2'h3;

    // feedback divider values
    localparam logic [7:0] FB_INT_RST = 8'h23;
    localparam logic [15:0] FB_FRAC_RST = 16'h2800;

    // dac baseline field
    localparam int DAC_BASE_LSB = 0;
    localparam int DAC_BASE_W = 5;
    localparam logic [4:0] DAC_BASE_RST = 5'h04;
    localparam int DAC_CODE_W = 6;

    // system clock divide field
    localparam int SYS_DIV_LSB = 0;
    localparam int SYS_DIV_W = 5;
    localparam logic [4:0] SYS_DIV_RST = 5'h0c;

    // bias status field positions
    localparam int BIAS_DONE_BIT = 0;
    localparam int BIAS_FAIL_BIT = 1;
    localparam int BIAS_SEL_LSB = 2;
    localparam int BIAS_EFF_LSB = 5;
    localparam int BIAS_RAW_BIT = 8;
    localparam int BIAS_SET_W = 3;

endpackage

// ---- rtl/tcc_setting_decode.sv ----
/*
 * tcc_setting_decode: turns the stored register fields into the
 * settings that the analog converter loop consumes.
 * assumes: inputs come straight from registers; outputs are
 * combinational and are registered by the instantiating module.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_setting_decode (
    // stored fields
    input wire logic [2:0] ref_code,
    input wire logic feedback_modulator_enable,
    input wire logic [1:0] feedback_modulator_order,
    input wire logic [15:0] feedback_fraction_value,
    input wire logic [4:0] dac_baseline,
    // dynamic value from the dac modulator, 0 to 16
    input wire logic [4:0] dac_dynamic,
    // decoded settings
    output logic [4:0] ref_divide_ratio,
    output logic multi_modulus_divider_active,
    output logic [1:0] modulator_order_eff,
    output logic [15:0] fraction_eff,
    output logic [5:0] dac_code
);

    // reference divide ratio; unassigned codes fall back to bypass
    always_comb begin
        case (ref_code)
            tcc_regs_pkg::REF_CODE_BYPASS: ref_divide_ratio = 5'h01;
            tcc_regs_pkg::REF_CODE_DIV2: ref_divide_ratio = 5'h02;
            tcc_regs_pkg::REF_CODE_DIV4: ref_divide_ratio = 5'h04;
            tcc_regs_pkg::REF_CODE_DIV8: ref_divide_ratio = 5'h08;
            tcc_regs_pkg::REF_CODE_DIV16: ref_divide_ratio = 5'h10;
            default: ref_divide_ratio = 5'h01;
        endcase
    end

    // with the modulator off the divider runs on the integer alone
    always_comb begin
        multi_modulus_divider_active = feedback_modulator_enable;
        if (feedback_modulator_enable) begin
            modulator_order_eff = feedback_modulator_order;
            fraction_eff = feedback_fraction_value;
        end else begin
            modulator_order_eff = tcc_regs_pkg::ORDER_INTEGER;
            fraction_eff = 16'h0000;
        end
    end

    // dac input is baseline plus dynamic term, one bit wider to hold 32
    always_comb begin
        dac_code = {1'b0, dac_baseline} + {1'b0, dac_dynamic};
    end

endmodule

`default_nettype wire

// ---- sim/tcc_config_regs_checker.sv ----
/*
 * tcc_config_regs_checker: port-level assertions for the register bank.
 * assumes: bound to tcc_config_regs, one clock mclk, reset rst_n low.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_config_regs_checker (
    // clock and reset
    input wire logic mclk,
    input wire logic rst_n,
    // register port
    input wire logic reg_wr_en,
    input wire logic reg_rd_en,
    input wire logic [7:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic [15:0] reg_rdata,
    input wire logic reg_rvalid,
    // analog side inputs
    input wire logic [4:0] dac_dynamic,
    input wire logic bias_cal_done_in,
    input wire logic bias_cal_fail_in,
    input wire logic [2:0] bias_cal_sel_in,
    input wire logic [2:0] bias_cal_eff_in,
    input wire logic bias_cal_cmp_in,
    // settings
    input wire logic [4:0] ref_divide_ratio,
    input wire logic multi_modulus_divider_active,
    input wire logic [1:0] feedback_modulator_order,
    input wire logic [7:0] feedback_integer_value,
    input wire logic [15:0] feedback_fraction_value,
    input wire logic [5:0] dac_code,
    input wire logic [4:0] sys_divide_integer
);
    // write data slices, so that $past sees plain signals
    logic [2:0] wd_ref;
    logic [4:0] wd_sys;
    logic [7:0] wd_int;
    assign wd_ref = reg_wdata[2:0];
    assign wd_sys = reg_wdata[4:0];
    assign wd_int = reg_wdata[7:0];
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n);

    property p_rvalid; reg_rvalid == $past(reg_rd_en); endproperty
    a_rvalid: assert property (p_rvalid) else $error("read answer late");
    property p_ratio; reg_wr_en && reg_addr == 8'h00 |=> ##1 ref_divide_ratio ==
        (($past(wd_ref, 2) > 3'h4) ? 5'h01 : (5'h01 << $past(wd_ref, 2))); endproperty
    a_ratio: assert property (p_ratio) else $error("divide ratio wrong");
    property p_int; reg_wr_en && reg_addr == 8'h02 |=> ##1
        feedback_integer_value == $past(wd_int, 2); endproperty
    a_int: assert property (p_int) else $error("integer setting wrong");
    property p_off; !multi_modulus_divider_active |->
        feedback_modulator_order == 2'h0 && feedback_fraction_value == 16'h0000; endproperty
    a_off: assert property (p_off) else $error("modulator not idle");
    property p_order; (reg_wr_en && reg_addr == 8'h01 && wd_ref[1:0] == 2'h3 && reg_wdata[7])
        ##1 multi_modulus_divider_active |=>
        feedback_modulator_order == $past(feedback_modulator_order); endproperty
    a_order: assert property (p_order) else $error("reserved order used");
    property p_dac; $past(rst_n) && $past(rst_n, 2) && $past(rst_n, 3) && !$past(reg_wr_en)
        && !$past(reg_wr_en, 2) |-> (dac_code - $past(dac_dynamic)) ==
        ($past(dac_code) - $past(dac_dynamic, 2)); endproperty
    a_dac: assert property (p_dac) else $error("dac sum wrong");
    property p_busy; reg_rd_en && reg_addr == 8'h06 && !bias_cal_done_in |=>
        reg_rdata == {7'h00, $past(bias_cal_cmp_in), 8'h00}; endproperty
    a_busy: assert property (p_busy) else $error("busy status wrong");
    property p_done; reg_rd_en && reg_addr == 8'h06 && bias_cal_done_in |=> reg_rdata ==
        {7'h00, $past(bias_cal_cmp_in), $past(bias_cal_eff_in), $past(bias_cal_sel_in),
        $past(bias_cal_fail_in), 1'b1}; endproperty
    a_done: assert property (p_done) else $error("done status wrong");
    property p_hole; reg_rd_en && reg_addr > 8'h06 |=> reg_rdata == 16'h0000; endproperty
    a_hole: assert property (p_hole) else $error("unmapped read not zero");
    property p_sys; reg_wr_en && reg_addr == 8'h05 |=> ##1
        sys_divide_integer == $past(wd_sys, 2); endproperty
    a_sys: assert property (p_sys) else $error("system divide wrong");
endmodule

bind tcc_config_regs tcc_config_regs_checker i_tcc_config_regs_checker (
    .mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .dac_dynamic(dac_dynamic), .bias_cal_done_in(bias_cal_done_in),
    .bias_cal_fail_in(bias_cal_fail_in), .bias_cal_sel_in(bias_cal_sel_in),
    .bias_cal_eff_in(bias_cal_eff_in), .bias_cal_cmp_in(bias_cal_cmp_in),
    .ref_divide_ratio(ref_divide_ratio),
    .multi_modulus_divider_active(multi_modulus_divider_active),
    .feedback_modulator_order(feedback_modulator_order),
    .feedback_integer_value(feedback_integer_value),
    .feedback_fraction_value(feedback_fraction_value), .dac_code(dac_code),
    .sys_divide_integer(sys_divide_integer));

`default_nettype wire

// ---- sim/tcc_config_regs_bench.sv ----
/*
 * tcc_config_regs_bench: self-checking bench for the register bank.
 * assumes: the checker binds itself; inputs change on falling edges.
 */
`timescale 1ns/1ps
`default_nettype none

module tcc_config_regs_bench;
    // clock, reset and register port
    logic mclk = 1'b0;
    logic rst_n = 1'b0;
    logic reg_wr_en = 1'b0;
    logic reg_rd_en = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] reg_rdata;
    logic reg_rvalid;
    // analog side inputs
    logic [4:0] dac_dynamic = 5'h00;
    logic bias_cal_done_in = 1'b0;
    logic bias_cal_fail_in = 1'b0;
    logic [2:0] bias_cal_sel_in = 3'h0;
    logic [2:0] bias_cal_eff_in = 3'h0;
    logic bias_cal_cmp_in = 1'b0;
    // settings
    logic [4:0] ratio;
    logic multi_modulus_divider;
    logic [1:0] order;
    logic [7:0] fint;
    logic [15:0] frac;
    logic [5:0] dac_code;
    logic [4:0] sysdiv;
    int mismatches = 0;
    int compares = 0;

    tcc_config_regs i_tcc_config_regs (.mclk(mclk), .rst_n(rst_n), .reg_wr_en(reg_wr_en),
        .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .dac_dynamic(dac_dynamic),
        .bias_cal_done_in(bias_cal_done_in), .bias_cal_fail_in(bias_cal_fail_in),
        .bias_cal_sel_in(bias_cal_sel_in), .bias_cal_eff_in(bias_cal_eff_in),
        .bias_cal_cmp_in(bias_cal_cmp_in), .ref_divide_ratio(ratio),
        .multi_modulus_divider_active(multi_modulus_divider), .feedback_modulator_order(order),
        .feedback_integer_value(fint), .feedback_fraction_value(frac),
        .dac_code(dac_code), .sys_divide_integer(sysdiv));

    // free-running 100 MHz clock
    always #5 mclk = ~mclk;

    // compare and count
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // one write, then wait until the settings have followed it
    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        reg_wr_en = 1'b1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge mclk);
        reg_wr_en = 1'b0;
        repeat (2) @(negedge mclk);
    endtask
    // one read, answer judged in the cycle it stands
    task automatic rd(input logic [7:0] a, input logic [15:0] exp);
        reg_rd_en = 1'b1;
        reg_addr = a;
        @(negedge mclk);
        reg_rd_en = 1'b0;
        chk({15'h0000, reg_rvalid}, 16'h0001);
        chk(reg_rdata, exp);
        @(negedge mclk);
    endtask

    // reset values of every register and of the ratio, integer and fraction settings
    task automatic t_reset;
        rd(8'h00, 16'h0001);
        rd(8'h01, 16'h0081);
        rd(8'h02, 16'h0023);
        rd(8'h03, 16'h2800);
        rd(8'h04, 16'h0004);
        rd(8'h05, 16'h000c);
        rd(8'h06, 16'h0000);
        chk({11'h000, ratio}, 16'h0002);
        chk({8'h00, fint}, 16'h0023);
        chk(frac, 16'h2800);
    endtask
    // every reference code, reserved bits set on each write
    task automatic t_ref;
        for (int c = 0; c < 8; c++) begin
            wr(8'h00, {13'h1fff, c[2:0]});
            rd(8'h00, {13'h0000, c[2:0]});
            chk({11'h000, ratio}, (c < 5) ? (16'h0001 << c) : 16'h0001);
        end
    endtask
    // modulator orders, disable, refused order code
    task automatic t_mod;
        for (int o = 0; o < 3; o++) begin
            wr(8'h01, {8'h00, 1'b1, 5'h1f, o[1:0]});
            rd(8'h01, {8'h00, 1'b1, 5'h00, o[1:0]});
            chk({13'h0000, multi_modulus_divider, order}, {13'h0000, 1'b1, o[1:0]});
        end
        wr(8'h01, 16'h0083);
        rd(8'h01, 16'h0082);
        chk({13'h0000, multi_modulus_divider, order}, 16'h0006);
        wr(8'h01, 16'h0003);
        rd(8'h01, 16'h0002);
        chk({13'h0000, multi_modulus_divider, order}, 16'h0000);
        chk(frac, 16'h0000);
        wr(8'h01, 16'h0083);
        rd(8'h01, 16'h0082);
        chk(frac, 16'h2800);
    endtask
    // feedback values, writes to status and unmapped places
    task automatic t_fb;
        wr(8'h02, 16'hffa5);
        rd(8'h02, 16'h00a5);
        chk({8'h00, fint}, 16'h00a5);
        wr(8'h03, 16'hffff);
        rd(8'h03, 16'hffff);
        chk(frac, 16'hffff);
        wr(8'h06, 16'hffff);
        rd(8'h06, 16'h0000);
        wr(8'h20, 16'hffff);
        rd(8'h20, 16'h0000);
    endtask
    // dac code follows baseline plus dynamic term at its extremes
    task automatic t_dac;
        wr(8'h04, 16'hfff0);
        rd(8'h04, 16'h0010);
        dac_dynamic = 5'h10;
        @(negedge mclk);
        chk({10'h000, dac_code}, 16'h0020);
        wr(8'h04, 16'h0000);
        chk({10'h000, dac_code}, 16'h0010);
        dac_dynamic = 5'h00;
        @(negedge mclk);
        chk({10'h000, dac_code}, 16'h0000);
    endtask
    // system divide values 0x0a and 0x0f, upper write bits dropped
    task automatic t_sys;
        wr(8'h05, 16'h00ea);
        rd(8'h05, 16'h000a);
        chk({11'h000, sysdiv}, 16'h000a);
        wr(8'h05, 16'h000f);
        chk({11'h000, sysdiv}, 16'h000f);
    endtask
    // calibration running, failed and passed
    task automatic t_bias;
        bias_cal_fail_in = 1'b1;
        bias_cal_sel_in = 3'h5;
        bias_cal_eff_in = 3'h3;
        bias_cal_cmp_in = 1'b1;
        rd(8'h06, 16'h0100);
        bias_cal_done_in = 1'b1;
        rd(8'h06, 16'h0177);
        bias_cal_fail_in = 1'b0;
        bias_cal_cmp_in = 1'b0;
        rd(8'h06, 16'h0075);
    endtask

    // verdict and end of run
    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        repeat (4) @(negedge mclk);
        rst_n = 1'b1;
        @(negedge mclk);
        t_reset;
        t_ref;
        t_mod;
        t_fb;
        t_dac;
        t_sys;
        t_bias;
        close_out;
    end
    // watchdog, about fifteen times the expected run
    initial begin
        #20000;
        mismatches++;
        close_out;
    end
endmodule

`default_nettype wire
